// ==== design/fcq_pkg.sv ====
package fcq_pkg;

  localparam int AW = 21;
  localparam int DW = 16;

  typedef enum logic [2:0] {
    OP_READ,
    OP_PROGRAM,
    OP_QUERY,
    OP_RESET,
    OP_SEC_ENTER,
    OP_SEC_EXIT,
    OP_SEC_LOCK
  } fcq_op_t;

  typedef enum logic [2:0] {
    SK_WR,
    SK_RD,
    SK_RDY,
    SK_DLY,
    SK_END
  } fcq_kind_t;

  typedef struct packed {
    fcq_kind_t       kind;
    logic [AW-1:0]   addr;
    logic [DW-1:0]   data;
  } fcq_step_t;

  // bus timing, figures in ns, counts at 125 MHz
  localparam int CLK_MHZ     = 125;
  localparam int T_SETUP_NS  = 8;
  localparam int T_WP_NS     = 35;
  localparam int T_ACC_NS    = 70;
  localparam int T_HOLD_NS   = 8;
  localparam int T_GLITCH_NS = 5;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] SETUP_CYC  = 4'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] WP_CYC     = 4'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] ACC_CYC    = 4'((T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES);
  localparam logic [3:0] HOLD_CYC   = 4'((T_HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] GLITCH_CYC = 4'((T_GLITCH_NS * CLK_MHZ + 999) / 1000);

  // long waits, figures in us
  localparam int T_PROT_US  = 150;
  localparam int T_PWRUP_US = 50;
  localparam int PROT_CYC   = T_PROT_US * CLK_MHZ;
  localparam int PWRUP_CYC  = T_PWRUP_US * CLK_MHZ;

  // command addresses, word mode
  localparam logic [AW-1:0] ADDR_UNLOCK1   = 21'h000555;
  localparam logic [AW-1:0] ADDR_UNLOCK2   = 21'h0002aa;
  localparam logic [AW-1:0] ADDR_QUERY     = 21'h000055;
  localparam logic [AW-1:0] ADDR_QID_FIRST = 21'h000010;
  localparam logic [AW-1:0] ADDR_PROT      = 21'h000002;
  localparam logic [AW-1:0] ADDR_ZERO      = 21'h000000;

  // command data
  localparam logic [DW-1:0] D_UNLOCK1   = 16'h00aa;
  localparam logic [DW-1:0] D_UNLOCK2   = 16'h0055;
  localparam logic [DW-1:0] D_PROGRAM   = 16'h00a0;
  localparam logic [DW-1:0] D_QUERY     = 16'h0098;
  localparam logic [DW-1:0] D_RESET     = 16'h00f0;
  localparam logic [DW-1:0] D_SEC_ENTER = 16'h0088;
  localparam logic [DW-1:0] D_SEC_EXIT  = 16'h0090;
  localparam logic [DW-1:0] D_SEC_EXIT2 = 16'h0000;
  localparam logic [DW-1:0] D_PROT      = 16'h0060;
  localparam logic [DW-1:0] D_PROT_VFY  = 16'h0040;

  // query table layout within a query sequence, and the verify read index of the lock sequence
  localparam logic [4:0] QRY_RD_FIRST = 5'h02;
  localparam logic [4:0] QRY_RD_LAST  = 5'h18;
  localparam logic [4:0] QRY_EXIT_IDX = 5'h19;
  localparam logic [4:0] LOCK_VFY_IDX = 5'h06;

  localparam logic [DW-1:0] CFI_EXPECT [0:22] = '{
    16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0040, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0027, 16'h0036, 16'h0000,
    16'h0000, 16'h0003, 16'h0000, 16'h0009, 16'h0000, 16'h0005, 16'h0000,
    16'h0004, 16'h0000
  };

endpackage

// ==== design/fcq_cycle.sv ====
`timescale 1ns/1ps
// one timed flash bus cycle, read or write
module fcq_cycle
  import fcq_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire logic                  start,
  input  wire logic                  write,
  input  wire logic [fcq_pkg::AW-1:0] addr,
  input  wire logic [fcq_pkg::DW-1:0] wdata,
  output logic                       done,
  output logic [fcq_pkg::DW-1:0]     rdata,
  output logic                       flash_ce_n,
  output logic                       flash_we_n,
  output logic                       flash_oe_n,
  output logic [fcq_pkg::AW-1:0]     flash_addr,
  output logic [fcq_pkg::DW-1:0]     flash_dq_o,
  output logic                       flash_dq_oe,
  input  wire logic [fcq_pkg::DW-1:0] flash_dq_i
);
  import fcq_pkg::*;

  typedef enum {C_IDLE, C_SETUP, C_PULSE, C_HOLD} fcq_cst_t;

  fcq_cst_t          cst_q;
  logic [3:0]        cnt_q;
  logic              wr_q;
  logic [DW-1:0]     dq_s1_q;
  logic [DW-1:0]     dq_s2_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= flash_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // oe_n is only lowered for reads and we_n only for writes, never both
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cst_q       <= C_IDLE;
      cnt_q       <= '0;
      wr_q        <= 1'b0;
      done        <= 1'b0;
      rdata       <= '0;
      flash_ce_n  <= 1'b1;
      flash_we_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
      flash_addr  <= '0;
      flash_dq_o  <= '0;
      flash_dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (cst_q)
        C_IDLE: begin
          if (start) begin
            flash_addr <= addr;
            flash_ce_n <= 1'b0;
            wr_q       <= write;
            flash_dq_o  <= wdata;
            flash_dq_oe <= write;
            cnt_q      <= SETUP_CYC - 4'h1;
            cst_q      <= C_SETUP;
          end
        end
        C_SETUP: begin
          if (cnt_q == 4'h0) begin
            if (wr_q) begin
              flash_we_n <= 1'b0; // R9
              cnt_q      <= WP_CYC - 4'h1; // R8
            end else begin
              flash_oe_n <= 1'b0;
              cnt_q      <= ACC_CYC - 4'h1;
            end
            cst_q <= C_PULSE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        C_PULSE: begin
          if (cnt_q == 4'h0) begin
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (!wr_q) begin
              rdata <= dq_s2_q;
            end
            cnt_q <= HOLD_CYC - 4'h1;
            cst_q <= C_HOLD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        C_HOLD: begin
          if (cnt_q == 4'h0) begin
            flash_ce_n  <= 1'b1;
            flash_dq_oe <= 1'b0;
            done        <= 1'b1;
            cst_q       <= C_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
      endcase
    end
  end

  property p_logic_inhibit;
    @(posedge mclk) disable iff (!rstn)
      !flash_we_n |-> (flash_oe_n && !flash_ce_n && flash_dq_oe);
  endproperty
  a_logic_inhibit: assert property (p_logic_inhibit) // R9
    else $error("write strobe low without a valid write setting");

  property p_glitch_width;
    @(posedge mclk) disable iff (!rstn)
      $fell(flash_we_n) |-> (!flash_we_n) [*5] ##1 flash_we_n;
  endproperty
  a_glitch_width: assert property (p_glitch_width) // R8
    else $error("write pulse not exactly five cycles");

endmodule

// ==== design/fcq_host.sv ====
`timescale 1ns/1ps
// Summary of operation
// R1 - secure region lockable only once, reads unlimited
// R2 - no accelerated or bypass programming in region
// R3 - three-cycle enter, then in-system protect algorithm
// R4 - exit secure region after lock and verify
// R5 - locked region never unlocked nor changed
// R6 - unlock cycles precede every program command
// R7 - no writes while supply below lockout threshold
// R8 - strobes never shorter than glitch filter width
// R9 - write only with ce, we low, oe high
// R10 - no command writes during power-up interval
// R11 - query command 98h written to address 55h
// R12 - reset command leaves query mode
// R13 - query entry only when device ready
// R14 - query also accepted from identification mode
// R15 - query string QRY at 10h to 12h
// R16 - command set 0002h at 13h, zero 14h
// R17 - extended table pointer 0040h at 15h
// R18 - zero at 17h through 1Ah
// R19 - supply limits 0027h, 0036h; no program-voltage pin
// R20 - typical timeouts 0003h, 0009h; others zero
// R21 - maximum multipliers 0005h, 0004h; others zero
module fcq_host
  import fcq_pkg::*;
#(
  parameter int PROT_WAIT  = fcq_pkg::PROT_CYC,
  parameter int PWRUP_WAIT = fcq_pkg::PWRUP_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire fcq_pkg::fcq_op_t       cmd_op,
  input  wire logic [fcq_pkg::AW-1:0] cmd_addr,
  input  wire logic [fcq_pkg::DW-1:0] cmd_wdata,
  output logic                        rsp_valid,
  output logic                        rsp_err,
  output logic [fcq_pkg::DW-1:0]      rsp_rdata,
  output logic                        secure_mode,
  output logic                        secure_locked,
  output logic                        flash_ce_n,
  output logic                        flash_we_n,
  output logic                        flash_oe_n,
  output logic                        flash_byte_n,
  output logic                        flash_accel_n,
  output logic [fcq_pkg::AW-1:0]      flash_addr,
  output logic [fcq_pkg::DW-1:0]      flash_dq_o,
  output logic                        flash_dq_oe,
  input  wire logic [fcq_pkg::DW-1:0] flash_dq_i,
  input  wire logic                   flash_ready,
  input  wire logic                   supply_ok
);
  import fcq_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  typedef enum {ST_INIT, ST_IDLE, ST_STEP, ST_CYC, ST_WAIT, ST_DONE} fcq_st_t;
  fcq_st_t        st_q;
  fcq_op_t        op_q;
  logic [4:0]     idx_q;
  logic [19:0]    cnt_q;
  logic [AW-1:0]  addr_q;
  logic [DW-1:0]  wdata_q;
  logic           err_q;
  logic           sec_q;
  logic           locked_q;
  logic [DW-1:0]  last_wdata_q;
  logic           rdy_s1_q, rdy_s2_q;
  logic           sup_s1_q, sup_s2_q;
  fcq_step_t      step;
  logic           cyc_start;
  logic           cyc_write;
  logic           cyc_done;
  logic [DW-1:0]  cyc_rdata;
  logic           take;
  logic           refuse;
  logic           supply_low;
  function automatic fcq_step_t wr(logic [AW-1:0] a, logic [DW-1:0] d);
    return '{SK_WR, a, d};
  endfunction
  // unlock pair shared by the program and secure-region command sequences
  function automatic fcq_step_t unlock(logic [4:0] i);
    return (i == 5'h0) ? wr(ADDR_UNLOCK1, D_UNLOCK1) : wr(ADDR_UNLOCK2, D_UNLOCK2);
  endfunction
  function automatic fcq_step_t step_of(fcq_op_t op, logic [4:0] i, logic [AW-1:0] a,
                                        logic [DW-1:0] d);
    fcq_step_t s;
    s = '{SK_END, ADDR_ZERO, D_SEC_EXIT2};
    unique case (op)
      OP_READ: if (i == 5'h0) s = '{SK_RD, a, D_SEC_EXIT2};
      OP_PROGRAM: begin
        if (i < 5'h2) s = unlock(i); // R6
        else if (i == 5'h2) s = wr(ADDR_UNLOCK1, D_PROGRAM);
        else if (i == 5'h3) s = wr(a, d);
        else if (i == 5'h4) s = '{SK_RDY, ADDR_ZERO, D_SEC_EXIT2};
      end
      OP_QUERY: begin
        if (i == 5'h0) s = '{SK_RDY, ADDR_ZERO, D_SEC_EXIT2}; // R13
        else if (i == 5'h1) s = wr(ADDR_QUERY, D_QUERY); // R11
        else if (i <= QRY_RD_LAST)
          s = '{SK_RD, ADDR_QID_FIRST + AW'(i - QRY_RD_FIRST), D_SEC_EXIT2};
        else if (i == QRY_EXIT_IDX) s = wr(ADDR_ZERO, D_RESET); // R12
      end
      OP_RESET: if (i == 5'h0) s = wr(ADDR_ZERO, D_RESET); // R12
      OP_SEC_ENTER: begin
        if (i < 5'h2) s = unlock(i);
        else if (i == 5'h2) s = wr(ADDR_UNLOCK1, D_SEC_ENTER); // R3
      end
      OP_SEC_EXIT: begin
        if (i < 5'h2) s = unlock(i);
        else if (i == 5'h2) s = wr(ADDR_UNLOCK1, D_SEC_EXIT);
        else if (i == 5'h3) s = wr(ADDR_ZERO, D_SEC_EXIT2);
      end
      OP_SEC_LOCK: begin
        if (i < 5'h2) s = unlock(i); // R3
        else if (i == 5'h2) s = wr(ADDR_UNLOCK1, D_SEC_ENTER);
        else if (i == 5'h3) s = wr(ADDR_PROT, D_PROT);
        else if (i == 5'h4) s = '{SK_DLY, ADDR_ZERO, D_SEC_EXIT2};
        else if (i == 5'h5) s = wr(ADDR_PROT, D_PROT_VFY);
        else if (i == LOCK_VFY_IDX) s = '{SK_RD, ADDR_PROT, D_SEC_EXIT2};
        else if (i < 5'h9) s = unlock(i - 5'h7); // R4
        else if (i == 5'h9) s = wr(ADDR_UNLOCK1, D_SEC_EXIT);
        else if (i == 5'ha) s = wr(ADDR_ZERO, D_SEC_EXIT2);
      end
      default: s = '{SK_END, ADDR_ZERO, D_SEC_EXIT2};
    endcase
    return s;
  endfunction
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
      sup_s1_q <= 1'b0;
      sup_s2_q <= 1'b0;
    end else begin
      rdy_s1_q <= flash_ready;
      rdy_s2_q <= rdy_s1_q;
      sup_s1_q <= supply_ok;
      sup_s2_q <= sup_s1_q;
    end
  end
  assign supply_low = !sup_s2_q;
  assign step       = step_of(op_q, idx_q, addr_q, wdata_q);
  assign cmd_ready  = (st_q == ST_IDLE);
  assign take       = cmd_valid && cmd_ready;
  // a region once locked takes neither a second lock nor programs
  assign refuse     = ((cmd_op == OP_SEC_LOCK) && locked_q) // R1
                   || ((cmd_op == OP_PROGRAM) && sec_q && locked_q) // R5
                   || ((cmd_op != OP_READ) && supply_low); // R7
  assign cyc_start  = (st_q == ST_STEP) && (step.kind == SK_WR || step.kind == SK_RD)
                   && !(step.kind == SK_WR && supply_low); // R7
  assign cyc_write  = (step.kind == SK_WR);
  // word mode only; the accelerated path is never used by this host
  assign flash_byte_n  = 1'b1;
  assign flash_accel_n = 1'b1; // R2
  assign secure_mode   = sec_q;
  assign secure_locked = locked_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q      <= ST_INIT;
      op_q      <= OP_READ;
      idx_q     <= '0;
      cnt_q     <= '0;
      addr_q    <= '0;
      wdata_q   <= '0;
      err_q     <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_err   <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= 1'b0;
      unique case (st_q)
        ST_INIT: begin
          // bus stays idle through supply ramp
          if (cnt_q == 20'(PWRUP_WAIT - 1)) st_q <= ST_IDLE; // R10
          else cnt_q <= cnt_q + 20'h1;
        end
        ST_IDLE: begin
          if (take) begin
            op_q    <= cmd_op;
            addr_q  <= cmd_addr;
            wdata_q <= cmd_wdata;
            idx_q   <= '0;
            err_q   <= refuse;
            st_q    <= refuse ? ST_DONE : ST_STEP;
          end
        end
        ST_STEP: begin
          unique case (step.kind)
            SK_WR, SK_RD: begin
              if (cyc_start) st_q <= ST_CYC;
              else begin
                err_q <= 1'b1;
                st_q  <= ST_DONE;
              end
            end
            SK_RDY: if (rdy_s2_q) idx_q <= idx_q + 5'h1;
            SK_DLY: begin
              cnt_q <= 20'(PROT_WAIT - 1);
              st_q  <= ST_WAIT;
            end
            SK_END: st_q <= ST_DONE;
          endcase
        end
        ST_CYC: begin
          if (cyc_done) begin
            if (step.kind == SK_RD) begin
              rsp_rdata <= cyc_rdata;
              if (op_q == OP_QUERY
                  && cyc_rdata != CFI_EXPECT[idx_q - QRY_RD_FIRST]) err_q <= 1'b1; // R15
              if (op_q == OP_SEC_LOCK && !cyc_rdata[0]) err_q <= 1'b1;
            end
            idx_q <= idx_q + 5'h1;
            st_q  <= ST_STEP;
          end
        end
        ST_WAIT: begin
          if (cnt_q == 20'h0) begin
            idx_q <= idx_q + 5'h1;
            st_q  <= ST_STEP;
          end else cnt_q <= cnt_q - 20'h1;
        end
        ST_DONE: begin
          rsp_valid <= 1'b1;
          rsp_err   <= err_q;
          st_q      <= ST_IDLE;
        end
      endcase
    end
  end
  // secure-region state as the host tracks it; reset clears locked_q though the device stays locked
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sec_q    <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      if (supply_low) sec_q <= 1'b0; // R7
      else if (cyc_done && cyc_write && last_wdata_q == D_SEC_ENTER
               && op_q != OP_PROGRAM) sec_q <= 1'b1;
      else if (cyc_done && cyc_write && last_wdata_q == D_SEC_EXIT2
               && (op_q == OP_SEC_EXIT || op_q == OP_SEC_LOCK)) sec_q <= 1'b0; // R4
      if (st_q == ST_DONE && op_q == OP_SEC_LOCK && !err_q) locked_q <= 1'b1; // R1
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) last_wdata_q <= '0;
    else if (cyc_start && cyc_write) last_wdata_q <= step.data;
  end
  fcq_cycle u_cycle (
    .mclk(mclk), .rstn(rstn), .start(cyc_start), .write(cyc_write), .addr(step.addr),
    .wdata(step.data), .done(cyc_done), .rdata(cyc_rdata), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i));

  property p_powerup_quiet;
    (st_q == ST_INIT) |-> (flash_we_n && flash_ce_n && !rsp_valid);
  endproperty
  a_powerup_quiet: assert property (p_powerup_quiet) // R10
    else $error("bus active during power-up interval");
  property p_lockout_no_write;
    supply_low |-> !(cyc_start && cyc_write);
  endproperty
  a_lockout_no_write: assert property (p_lockout_no_write) // R7
    else $error("write started below supply lockout");
  property p_query_addr;
    (cyc_start && cyc_write && op_q == OP_QUERY && step.data == D_QUERY)
      |-> step.addr == ADDR_QUERY;
  endproperty
  a_query_addr: assert property (p_query_addr) // R11
    else $error("query command at wrong address");
  property p_unlock_before_program;
    (cyc_start && op_q == OP_PROGRAM && idx_q == 5'h3) |-> last_wdata_q == D_PROGRAM;
  endproperty
  a_unlock_before_program: assert property (p_unlock_before_program) // R6
    else $error("program data without unlock sequence");
  property p_lock_once;
    (take && cmd_op == OP_SEC_LOCK && locked_q) |-> ##2 (rsp_valid && rsp_err);
  endproperty
  a_lock_once: assert property (p_lock_once) // R1
    else $error("second lock not refused");
  property p_exit_after_lock;
    (rsp_valid && !rsp_err && op_q == OP_SEC_LOCK) |-> !sec_q && locked_q;
  endproperty
  a_exit_after_lock: assert property (p_exit_after_lock) // R4
    else $error("lock finished without leaving secure region");
  property p_query_reset;
    (rsp_valid && !rsp_err && op_q == OP_QUERY) |-> last_wdata_q == D_RESET;
  endproperty
  a_query_reset: assert property (p_query_reset) // R12
    else $error("query finished without reset command");
  // ready is seen on the edge before the query write starts
  property p_query_ready;
    (cyc_start && cyc_write && op_q == OP_QUERY && step.data == D_QUERY)
      |-> $past(rdy_s2_q);
  endproperty
  a_query_ready: assert property (p_query_ready) // R13
    else $error("query entered while device busy");

endmodule

// ==== testbench/fcq_flash_model.sv ====
`timescale 1ns/1ps
// behavioural flash device; writes latch on the rising write strobe
module fcq_flash_model
  import fcq_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rstn,
  input  wire logic          ce_n,
  input  wire logic          we_n,
  input  wire logic          oe_n,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] dq_o,
  input  wire logic          dq_oe,
  output logic      [DW-1:0] dq_i,
  output logic               ready,
  input  wire logic          supply_ok,
  input  wire logic          hold_busy,
  output logic               viol
);
  localparam logic [DW-1:0] QT [0:22] = '{
    16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0040, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0027, 16'h0036, 16'h0000,
    16'h0000, 16'h0003, 16'h0000, 16'h0009, 16'h0000, 16'h0005, 16'h0000,
    16'h0004, 16'h0000
  };
  logic [DW-1:0] mem [0:31];
  logic [DW-1:0] last;
  logic          qmode, sec, locked, vfy, exitp, prog;
  logic [1:0]    ucnt;
  int            busy;
  realtime       t_low;
  wire           rd_en = !ce_n && !oe_n;
  wire [DW-1:0]  val = qmode ? ((addr >= 21'h10 && addr <= 21'h26) ? QT[addr[5:0] - 6'h10] : 16'h0)
                     : vfy ? {15'h0, locked} : mem[{sec, addr[3:0]}];
  // released bus shows the inverse of the last word, never a stale copy
  assign dq_i  = rd_en ? val : ~last;
  assign ready = busy == 0 && !hold_busy;
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = 16'hffff;
    {qmode, sec, vfy, exitp, prog, ucnt} = '0;
    locked = 1'h0;
    viol   = 1'h0;
    busy   = 0;
    last   = 16'h0;
  end
  always @(posedge mclk) begin
    if (rd_en) last <= val;
    if (busy > 0) busy <= busy - 1;
  end
  always @(negedge we_n) t_low = $realtime;
  always @(posedge we_n or negedge rstn) begin
    if (!rstn) begin
      {qmode, sec, vfy, exitp, prog, ucnt} = '0;
    end else if (!ce_n) begin
      if (oe_n !== 1'h1 || dq_oe !== 1'h1 || $realtime - t_low < 5.0 || !ready) viol = 1'h1;
      if (!supply_ok) begin
        {qmode, sec, vfy, exitp, prog, ucnt} = '0;
      end else if (prog) begin
        if (!(sec && locked)) mem[{sec, addr[3:0]}] = mem[{sec, addr[3:0]}] & dq_o;
        prog = 1'h0;
        busy = 20;
      end else if (dq_o[7:0] == 8'hf0) begin
        {qmode, vfy, ucnt} = '0;
      end else if (addr == 21'h55 && dq_o[7:0] == 8'h98) begin
        qmode = 1'h1;
      end else if (exitp) begin
        {sec, exitp} = '0;
      end else if (sec && addr == 21'h2 && dq_o[7:0] == 8'h60) begin
        locked = 1'h1;
      end else if (sec && addr == 21'h2 && dq_o[7:0] == 8'h40) begin
        vfy = 1'h1;
      end else if (ucnt == 2'h0 && addr == 21'h555 && dq_o[7:0] == 8'haa) begin
        ucnt = 2'h1;
      end else if (ucnt == 2'h1 && addr == 21'h2aa && dq_o[7:0] == 8'h55) begin
        ucnt = 2'h2;
      end else if (ucnt == 2'h2) begin
        ucnt = 2'h0;
        vfy  = 1'h0;
        case (dq_o[7:0])
          8'ha0: prog = 1'h1;
          8'h88: sec = 1'h1;
          8'h90: exitp = 1'h1;
          default: ;
        endcase
      end else begin
        ucnt = 2'h0;
      end
    end
  end
endmodule

// ==== testbench/fcq_host_tb.sv ====
`timescale 1ns/1ps
module fcq_host_tb;
  import fcq_pkg::*;
  typedef struct packed {
    fcq_op_t       op;
    logic [AW-1:0] a;
    logic [DW-1:0] d;
    logic          err;
    logic          rc;
    logic [DW-1:0] rd;
    logic          sm;
    logic          sl;
  } fcq_row_t;
  logic          mclk, rstn, cmd_valid, supply_ok, hold_busy;
  fcq_op_t       cmd_op;
  logic [AW-1:0] cmd_addr;
  logic [DW-1:0] cmd_wdata;
  wire           cmd_ready, rsp_valid, rsp_err, secure_mode, secure_locked;
  wire           ce_n, we_n, oe_n, byte_n, accel_n, dq_oe, ready, viol;
  wire [AW-1:0]  fa;
  wire [DW-1:0]  dqo, dqi, rsp_rdata;
  fcq_row_t      rows [0:15];
  int            errors, checks_done, n;

  fcq_host #(.PROT_WAIT(4), .PWRUP_WAIT(8)) uut (
    .mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .rsp_rdata(rsp_rdata), .secure_mode(secure_mode), .secure_locked(secure_locked),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_byte_n(byte_n),
    .flash_accel_n(accel_n), .flash_addr(fa), .flash_dq_o(dqo), .flash_dq_oe(dq_oe),
    .flash_dq_i(dqi), .flash_ready(ready), .supply_ok(supply_ok));
  fcq_flash_model mdl (
    .mclk(mclk), .rstn(rstn), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(fa), .dq_o(dqo),
    .dq_oe(dq_oe), .dq_i(dqi), .ready(ready), .supply_ok(supply_ok), .hold_busy(hold_busy),
    .viol(viol));

  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end

  task close_out;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk_bit(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask

  task chk_word(input logic [DW-1:0] g, input logic [DW-1:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask

  // one command, held until taken, then its single-cycle answer
  task run(input fcq_row_t r);
    @(posedge mclk);
    cmd_op    <= r.op;
    cmd_addr  <= r.a;
    cmd_wdata <= r.d;
    cmd_valid <= 1'h1;
    n = 0;
    do begin @(negedge mclk); n++; end while (cmd_ready !== 1'h1 && n < 3000);
    @(posedge mclk);
    cmd_valid <= 1'h0;
    do begin @(negedge mclk); n++; end while (rsp_valid !== 1'h1 && n < 6000);
    if (n >= 6000) begin
      errors++;
      close_out();
    end
    chk_bit(rsp_err, r.err);
    if (r.rc) chk_word(rsp_rdata, r.rd);
    chk_bit(secure_mode, r.sm);
    chk_bit(secure_locked, r.sl);
  endtask

  initial begin
    errors = 0;
    checks_done = 0;
    rstn = 1'h0;
    cmd_valid = 1'h0;
    cmd_op = OP_READ;
    cmd_addr = '0;
    cmd_wdata = '0;
    supply_ok = 1'h1;
    hold_busy = 1'h0;
    rows[0]  = '{OP_PROGRAM,  21'h3, 16'h1234, 1'h0, 1'h0, 16'h0,    1'h0, 1'h0};
    rows[1]  = '{OP_READ,     21'h3, 16'h0,    1'h0, 1'h1, 16'h1234, 1'h0, 1'h0};
    rows[2]  = '{OP_QUERY,    21'h0, 16'h0,    1'h0, 1'h1, 16'h0000, 1'h0, 1'h0};
    rows[3]  = '{OP_READ,     21'h3, 16'h0,    1'h0, 1'h1, 16'h1234, 1'h0, 1'h0};
    rows[4]  = '{OP_SEC_ENTER, 21'h0, 16'h0,   1'h0, 1'h0, 16'h0,    1'h1, 1'h0};
    rows[5]  = '{OP_PROGRAM,  21'h5, 16'habcd, 1'h0, 1'h0, 16'h0,    1'h1, 1'h0};
    rows[6]  = '{OP_READ,     21'h5, 16'h0,    1'h0, 1'h1, 16'habcd, 1'h1, 1'h0};
    rows[7]  = '{OP_SEC_EXIT, 21'h0, 16'h0,    1'h0, 1'h0, 16'h0,    1'h0, 1'h0};
    rows[8]  = '{OP_READ,     21'h5, 16'h0,    1'h0, 1'h1, 16'hffff, 1'h0, 1'h0};
    rows[9]  = '{OP_SEC_LOCK, 21'h0, 16'h0,    1'h0, 1'h1, 16'h0001, 1'h0, 1'h1};
    rows[10] = '{OP_SEC_LOCK, 21'h0, 16'h0,    1'h1, 1'h0, 16'h0,    1'h0, 1'h1};
    rows[11] = '{OP_SEC_ENTER, 21'h0, 16'h0,   1'h0, 1'h0, 16'h0,    1'h1, 1'h1};
    rows[12] = '{OP_PROGRAM,  21'h5, 16'h0000, 1'h1, 1'h0, 16'h0,    1'h1, 1'h1};
    rows[13] = '{OP_READ,     21'h5, 16'h0,    1'h0, 1'h1, 16'habcd, 1'h1, 1'h1};
    rows[14] = '{OP_SEC_EXIT, 21'h0, 16'h0,    1'h0, 1'h0, 16'h0,    1'h0, 1'h1};
    rows[15] = '{OP_RESET,    21'h0, 16'h0,    1'h0, 1'h0, 16'h0,    1'h0, 1'h1};
    repeat (3) @(posedge mclk);
    chk_bit(cmd_ready, 1'h0);
    chk_bit(we_n, 1'h1);
    chk_bit(dq_oe, 1'h0);
    rstn <= 1'h1;
    n = 0;
    do begin @(negedge mclk); n++; end while (cmd_ready !== 1'h1 && n < 100);
    chk_bit(n >= 8 && n < 100, 1'h1);
    chk_bit(accel_n, 1'h1);
    chk_bit(byte_n, 1'h1);
    for (int i = 0; i < 16; i++) run(rows[i]);
    // low supply: writes refused, reads still served
    @(posedge mclk);
    supply_ok <= 1'h0;
    repeat (4) @(posedge mclk);
    run('{OP_PROGRAM, 21'h3, 16'h0000, 1'h1, 1'h0, 16'h0, 1'h0, 1'h1});
    run('{OP_READ, 21'h3, 16'h0, 1'h0, 1'h1, 16'h1234, 1'h0, 1'h1});
    @(posedge mclk);
    supply_ok <= 1'h1;
    repeat (4) @(posedge mclk);
    // device busy: query entry must wait for ready
    hold_busy <= 1'h1;
    fork
      begin
        repeat (200) @(posedge mclk);
        hold_busy <= 1'h0;
      end
    join_none
    run('{OP_QUERY, 21'h0, 16'h0, 1'h0, 1'h1, 16'h0000, 1'h0, 1'h1});
    // mid-run reset forgets the lock; the device still refuses changes
    @(posedge mclk);
    rstn <= 1'h0;
    @(negedge mclk);
    chk_bit(secure_locked, 1'h0);
    chk_bit(ce_n, 1'h1);
    @(posedge mclk);
    rstn <= 1'h1;
    run('{OP_SEC_ENTER, 21'h0, 16'h0, 1'h0, 1'h0, 16'h0, 1'h1, 1'h0});
    run('{OP_PROGRAM, 21'h5, 16'h0000, 1'h0, 1'h0, 16'h0, 1'h1, 1'h0});
    run('{OP_READ, 21'h5, 16'h0, 1'h0, 1'h1, 16'habcd, 1'h1, 1'h0});
    run('{OP_SEC_EXIT, 21'h0, 16'h0, 1'h0, 1'h0, 16'h0, 1'h0, 1'h0});
    chk_bit(viol, 1'h0);
    close_out();
  end
endmodule
